// ---- logic/ddr2_sched_pkg.sv ----
package ddr2_sched_pkg;
    localparam logic [7:0]  TURNAROUND_OFS   = 8'h20;
    localparam logic [7:0]  REFRESH_CTL_OFS  = 8'h24;
    localparam logic [7:0]  SCHED_CFG_OFS    = 8'h30;
    localparam logic [7:0]  SCHED_STAT_OFS   = 8'h34;

    localparam logic [31:0] TURNAROUND_MASK  = 32'h1F1F1F1F;
    localparam logic [31:0] REFRESH_CTL_MASK = 32'h00001FF7;
    localparam logic [31:0] SCHED_CFG_MASK   = 32'h0FFF003F;
    localparam logic [31:0] REG_RESET        = 32'h00000000;

    localparam int WR2PRE_LSB   = 24;
    localparam int RD2PRE_LSB   = 16;
    localparam int WR2RD_LSB    = 8;
    localparam int RD2WR_LSB    = 0;
    localparam int GAP_W        = 5;
    localparam int IDLE_TO_LSB  = 8;
    localparam int IDLE_TO_W    = 5;
    localparam int MARGIN_LSB   = 4;
    localparam int MARGIN_W     = 4;
    localparam int BURST_LSB    = 0;
    localparam int BURST_W      = 3;
    localparam int PAGE_LIM_LSB = 0;
    localparam int PAGE_LIM_W   = 6;
    localparam int IVL_LSB      = 16;
    localparam int IVL_W        = 12;

    localparam int STAT_PEND_LSB  = 0;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_BLOCK_BIT = 8;
    localparam int STAT_SPEC_BIT  = 9;

    // units: idle, margin and interval in 32 clocks, page limit in 1024 clocks
    localparam int UNIT32_SH   = 5;
    localparam int UNIT1024_SH = 10;
    localparam int TMR_W       = 18;
    localparam int PEND_W      = 4;
    localparam logic [PEND_W-1:0] PEND_MAX = 4'h8;

    typedef enum logic [2:0] {
        SCH_IDLE    = 3'b001,
        SCH_CLOSE   = 3'b010,
        SCH_REFRESH = 3'b100
    } sched_state_t;
endpackage : ddr2_sched_pkg

// ---- logic/ddr2_turnaround_refresh_sched.sv ----
`timescale 1ns/10ps
// Summary of operation
// - A precharge to a bank waits the write-to-precharge gap after the last write to it.
// - A precharge to a bank waits the read-to-precharge gap after the last read of it.
// - A read waits the write-to-read gap after any write.
// - A write waits the read-to-write gap after any read.
// - Speculative refresh only while one or more but fewer than the limit are pending.
// - After the bus idles for the idle timeout in 32-clock units, with refresh pending, refresh.
// - Speculative refreshes run back to back until none pend or a new request arrives in the cycle a refresh is done.
// - Critical refresh and page close are raised early by the margin in 32-clock units.
// - The burst field plus one is how many refresh timeouts may accumulate.
// - At the accumulated limit, traffic is blocked and all pending refreshes are forced.
// - All pages are closed once before a refresh group, then a critical group runs whole; a speculative one may stop early.
// - The page timer closes a row after its limit in 1024 clocks; zero closes after each access.
module ddr2_turnaround_refresh_sched #(
    parameter int NB = 8,
    parameter int BW = $clog2(NB)
) (
    input  wire logic          CLOCK,
    input  wire logic          NRST,
    input  wire logic          CE,
    input  wire logic          PSEL,
    input  wire logic          PENABLE,
    input  wire logic          PWRITE,
    input  wire logic [7:0]    PADDR,
    input  wire logic [31:0]   PWDATA,
    output logic      [31:0]   PRDATA,
    output logic               PREADY,
    output logic               PSLVERR,
    input  wire logic          WR_ISSUE,
    input  wire logic          RD_ISSUE,
    input  wire logic          ACT_ISSUE,
    input  wire logic          PRE_ISSUE,
    input  wire logic [BW-1:0] CMD_BANK,
    input  wire logic          ALL_CLOSED,
    input  wire logic          REF_DONE,
    input  wire logic          REQ_NEW,
    input  wire logic          BUS_IDLE,
    output logic      [NB-1:0] PRE_ALLOW,
    output logic               RD_ALLOW,
    output logic               WR_ALLOW,
    output logic      [NB-1:0] PAGE_CLOSE_REQ,
    output logic               CLOSE_ALL_REQ,
    output logic               REF_REQ,
    output logic               REF_SPECULATIVE,
    output logic               TRAFFIC_BLOCK
);
    localparam int GW = ddr2_sched_pkg::GAP_W;
    localparam int TW = ddr2_sched_pkg::TMR_W;
    localparam int PW = ddr2_sched_pkg::PEND_W;
    if (NB < 2 || NB > 16 || (1 << BW) != NB) begin : g_nb_check
        $error("NB must be a power of two from 2 to 16");
    end

    logic [31:0]                  turn_r;
    logic [31:0]                  refc_r;
    logic [31:0]                  cfg_r;
    logic [31:0]                  stat_w;
    logic                         apb_wr;
    logic [GW-1:0]                wr2pre_gap;
    logic [GW-1:0]                rd2pre_gap;
    logic [GW-1:0]                wr2rd_gap;
    logic [GW-1:0]                rd2wr_gap;
    logic [GW-1:0]                wr2rd_cnt_r;
    logic [GW-1:0]                rd2wr_cnt_r;
    logic [GW-1:0]                wr2rd_cnt_nxt;
    logic [GW-1:0]                rd2wr_cnt_nxt;
    logic [TW-1:0]                margin_cyc;
    logic [TW-1:0]                idle_len;
    logic [TW-1:0]                ivl_len;
    logic [TW-1:0]                page_len;
    logic [TW-1:0]                idle_cnt_r;
    logic [TW-1:0]                ivl_cnt_r;
    logic                         ivl_tick;
    logic                         ivl_early;
    logic [PW-1:0]                acc_limit;
    logic [PW-1:0]                pend_r;
    logic [PW-1:0]                pend_nxt;
    logic                         crit_now;
    logic                         spec_now;
    logic                         spec_r;
    logic                         crit_r;
    ddr2_sched_pkg::sched_state_t state_r;
    ddr2_sched_pkg::sched_state_t state_nxt;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == ddr2_sched_pkg::TURNAROUND_OFS) || (a == ddr2_sched_pkg::REFRESH_CTL_OFS)
                || (a == ddr2_sched_pkg::SCHED_CFG_OFS) || (a == ddr2_sched_pkg::SCHED_STAT_OFS);
    endfunction : addr_hit

    // gap counter: loads gap-1 on issue so the later command is free exactly gap cycles on
    function automatic logic [GW-1:0] gap_next(input logic issue, input logic [GW-1:0] gap,
                                               input logic [GW-1:0] cnt);
        gap_next = issue ? ((gap == '0) ? '0 : gap - 5'h01) : ((cnt == '0) ? '0 : cnt - 5'h01);
    endfunction : gap_next

    // register file, reserved bits masked on write and read back as zero
    assign apb_wr = PSEL && PENABLE && PREADY && PWRITE;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            turn_r <= ddr2_sched_pkg::REG_RESET;
            refc_r <= ddr2_sched_pkg::REG_RESET;
            cfg_r  <= ddr2_sched_pkg::REG_RESET;
        end else if (CE && apb_wr) begin
            if (PADDR == ddr2_sched_pkg::TURNAROUND_OFS)
                turn_r <= PWDATA & ddr2_sched_pkg::TURNAROUND_MASK;
            if (PADDR == ddr2_sched_pkg::REFRESH_CTL_OFS)
                refc_r <= PWDATA & ddr2_sched_pkg::REFRESH_CTL_MASK;
            if (PADDR == ddr2_sched_pkg::SCHED_CFG_OFS)
                cfg_r <= PWDATA & ddr2_sched_pkg::SCHED_CFG_MASK;
        end
    end

    always_comb begin
        stat_w = '0;
        stat_w[ddr2_sched_pkg::STAT_PEND_LSB +: PW] = pend_r;
        stat_w[ddr2_sched_pkg::STAT_STATE_LSB +: 3] = state_r;
        stat_w[ddr2_sched_pkg::STAT_BLOCK_BIT]      = TRAFFIC_BLOCK;
        stat_w[ddr2_sched_pkg::STAT_SPEC_BIT]       = REF_SPECULATIVE;
    end

    // zero-wait slave: ready rises with the access phase, so each transfer takes two cycles
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
        end else if (CE) begin
            if (PSEL && !PENABLE && !PREADY) begin
                PREADY  <= 1'b1;
                PSLVERR <= !addr_hit(PADDR);
                case (PADDR)
                    ddr2_sched_pkg::TURNAROUND_OFS:  PRDATA <= turn_r;
                    ddr2_sched_pkg::REFRESH_CTL_OFS: PRDATA <= refc_r;
                    ddr2_sched_pkg::SCHED_CFG_OFS:   PRDATA <= cfg_r;
                    ddr2_sched_pkg::SCHED_STAT_OFS:  PRDATA <= stat_w;
                    default:                         PRDATA <= '0;
                endcase
            end else begin
                PREADY  <= 1'b0;
                PSLVERR <= 1'b0;
            end
        end
    end

    // field extraction and unit scaling
    assign wr2pre_gap = turn_r[ddr2_sched_pkg::WR2PRE_LSB +: GW];
    assign rd2pre_gap = turn_r[ddr2_sched_pkg::RD2PRE_LSB +: GW];
    assign wr2rd_gap  = turn_r[ddr2_sched_pkg::WR2RD_LSB +: GW];
    assign rd2wr_gap  = turn_r[ddr2_sched_pkg::RD2WR_LSB +: GW];
    assign margin_cyc = TW'(refc_r[ddr2_sched_pkg::MARGIN_LSB +: ddr2_sched_pkg::MARGIN_W])
                        << ddr2_sched_pkg::UNIT32_SH;
    assign idle_len   = TW'(refc_r[ddr2_sched_pkg::IDLE_TO_LSB +: ddr2_sched_pkg::IDLE_TO_W])
                        << ddr2_sched_pkg::UNIT32_SH;
    assign ivl_len    = TW'(cfg_r[ddr2_sched_pkg::IVL_LSB +: ddr2_sched_pkg::IVL_W])
                        << ddr2_sched_pkg::UNIT32_SH;
    assign page_len   = TW'(cfg_r[ddr2_sched_pkg::PAGE_LIM_LSB +: ddr2_sched_pkg::PAGE_LIM_W])
                        << ddr2_sched_pkg::UNIT1024_SH;
    assign acc_limit  = PW'(refc_r[ddr2_sched_pkg::BURST_LSB +: ddr2_sched_pkg::BURST_W])
                        + 4'h1;

    // global turnaround gaps
    assign wr2rd_cnt_nxt = gap_next(WR_ISSUE, wr2rd_gap, wr2rd_cnt_r);
    assign rd2wr_cnt_nxt = gap_next(RD_ISSUE, rd2wr_gap, rd2wr_cnt_r);

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            wr2rd_cnt_r <= '0;
            rd2wr_cnt_r <= '0;
            RD_ALLOW    <= 1'b1;
            WR_ALLOW    <= 1'b1;
        end else if (CE) begin
            wr2rd_cnt_r <= wr2rd_cnt_nxt;
            rd2wr_cnt_r <= rd2wr_cnt_nxt;
            RD_ALLOW    <= (wr2rd_cnt_nxt == '0);
            WR_ALLOW    <= (rd2wr_cnt_nxt == '0);
        end
    end

    // per-bank precharge gaps and page timers
    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_bank
            logic          hit;
            logic [GW-1:0] w2p_r;
            logic [GW-1:0] r2p_r;
            logic [GW-1:0] w2p_nxt;
            logic [GW-1:0] r2p_nxt;
            logic          open_r;
            logic          used_r;
            logic [TW-1:0] page_cnt_r;
            logic          page_due;

            assign hit     = (CMD_BANK == BW'(b));
            assign w2p_nxt = gap_next(WR_ISSUE && hit, wr2pre_gap, w2p_r);
            assign r2p_nxt = gap_next(RD_ISSUE && hit, rd2pre_gap, r2p_r);
            // limit zero: close once the row has served one access
            assign page_due = (page_len == '0) ? used_r
                            : (page_cnt_r >= page_len - margin_cyc);

            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    w2p_r        <= '0;
                    r2p_r        <= '0;
                    PRE_ALLOW[b] <= 1'b1;
                end else if (CE) begin
                    w2p_r        <= w2p_nxt;
                    r2p_r        <= r2p_nxt;
                    PRE_ALLOW[b] <= (w2p_nxt == '0) && (r2p_nxt == '0);
                end
            end

            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    open_r            <= 1'b0;
                    used_r            <= 1'b0;
                    page_cnt_r        <= '0;
                    PAGE_CLOSE_REQ[b] <= 1'b0;
                end else if (CE) begin
                    if ((PRE_ISSUE && hit) || ALL_CLOSED) begin
                        open_r     <= 1'b0;
                        used_r     <= 1'b0;
                        page_cnt_r <= '0;
                    end else if (ACT_ISSUE && hit) begin
                        open_r     <= 1'b1;
                        used_r     <= 1'b0;
                        page_cnt_r <= '0;
                    end else if (open_r) begin
                        if ((WR_ISSUE || RD_ISSUE) && hit)
                            used_r <= 1'b1;
                        if (!(&page_cnt_r))
                            page_cnt_r <= page_cnt_r + 18'h00001;
                    end
                    PAGE_CLOSE_REQ[b] <= open_r && page_due && !(PRE_ISSUE && hit)
                                         && !ALL_CLOSED;
                end
            end
        end
    endgenerate

    // refresh interval and bus idle timers
    assign ivl_tick  = (ivl_len != '0) && (ivl_cnt_r == ivl_len - 18'h00001);
    // ivl_len zero stops the interval timer altogether
    assign ivl_early = (ivl_len != '0) && (ivl_cnt_r + margin_cyc + 18'h00001 >= ivl_len);

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ivl_cnt_r  <= '0;
            idle_cnt_r <= '0;
        end else if (CE) begin
            ivl_cnt_r <= (ivl_tick || ivl_len == '0) ? '0 : ivl_cnt_r + 18'h00001;
            if (!BUS_IDLE || REQ_NEW)
                idle_cnt_r <= '0;
            else if (!(&idle_cnt_r))
                idle_cnt_r <= idle_cnt_r + 18'h00001;
        end
    end

    // pending count: a tick and a done in one cycle cancel, so no tick is lost
    always_comb begin
        pend_nxt = pend_r;
        if (ivl_tick && !(REF_DONE && pend_r != '0)) begin
            if (pend_r != ddr2_sched_pkg::PEND_MAX)
                pend_nxt = pend_r + 4'h1;
        end else if (!ivl_tick && REF_DONE && pend_r != '0) begin
            pend_nxt = pend_r - 4'h1;
        end
    end

    assign crit_now = (pend_r >= acc_limit)
                   || (pend_r + 4'h1 == acc_limit && ivl_early);
    assign spec_now = (pend_r != '0) && (pend_r < acc_limit) && BUS_IDLE && !REQ_NEW
                   && (idle_cnt_r >= idle_len);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ddr2_sched_pkg::SCH_IDLE: begin
                if (crit_now || spec_now)
                    state_nxt = ddr2_sched_pkg::SCH_CLOSE;
            end
            ddr2_sched_pkg::SCH_CLOSE: begin
                if (ALL_CLOSED)
                    state_nxt = ddr2_sched_pkg::SCH_REFRESH;
                else if (spec_r && REQ_NEW && !crit_now)
                    state_nxt = ddr2_sched_pkg::SCH_IDLE;
            end
            ddr2_sched_pkg::SCH_REFRESH: begin
                // the group runs back to back with no page close between refreshes
                if (pend_nxt == '0)
                    state_nxt = ddr2_sched_pkg::SCH_IDLE;
                else if (REF_DONE && spec_r && REQ_NEW && !crit_now)
                    state_nxt = ddr2_sched_pkg::SCH_IDLE;
            end
            default: state_nxt = ddr2_sched_pkg::SCH_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state_r <= ddr2_sched_pkg::SCH_IDLE;
            pend_r  <= '0;
            spec_r  <= 1'b0;
            crit_r  <= 1'b0;
        end else if (CE) begin
            state_r <= state_nxt;
            pend_r  <= pend_nxt;
            if (state_r == ddr2_sched_pkg::SCH_IDLE) begin
                crit_r <= crit_now;
                spec_r <= !crit_now && spec_now;
            end else if (crit_now) begin
                // a speculative group that reaches the limit turns critical
                crit_r <= 1'b1;
                spec_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            CLOSE_ALL_REQ   <= 1'b0;
            REF_REQ         <= 1'b0;
            REF_SPECULATIVE <= 1'b0;
            TRAFFIC_BLOCK   <= 1'b0;
        end else if (CE) begin
            CLOSE_ALL_REQ   <= (state_nxt == ddr2_sched_pkg::SCH_CLOSE);
            REF_REQ         <= (state_nxt == ddr2_sched_pkg::SCH_REFRESH);
            REF_SPECULATIVE <= (state_nxt != ddr2_sched_pkg::SCH_IDLE) && !crit_now
                               && (state_r == ddr2_sched_pkg::SCH_IDLE ? spec_now : spec_r);
            TRAFFIC_BLOCK   <= (state_nxt != ddr2_sched_pkg::SCH_IDLE) && (crit_now
                               || (crit_r && state_r != ddr2_sched_pkg::SCH_IDLE));
        end
    end
endmodule : ddr2_turnaround_refresh_sched

// ---- testbench/ddr2_mem_model.sv ----
`timescale 1ns/10ps
module ddr2_mem_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic close_all_req,
    input  wire logic ref_req,
    input  wire logic slow,
    output logic      all_closed,
    output logic      ref_done
);
    logic [3:0] wait_r;

    // slow mode leaves room to abort a group while pages close
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r     <= 4'h0;
            all_closed <= 1'b0;
            ref_done   <= 1'b0;
        end else begin
            all_closed <= 1'b0;
            ref_done   <= 1'b0;
            wait_r     <= 4'h0;
            if ((close_all_req && !all_closed) || (ref_req && !ref_done)) begin
                if (wait_r < (slow ? 4'hC : 4'h1)) begin
                    wait_r <= wait_r + 4'h1;
                end else begin
                    all_closed <= close_all_req;
                    ref_done   <= ref_req && !close_all_req;
                end
            end
        end
    end
endmodule : ddr2_mem_model

// ---- testbench/ddr2_sched_checker.sv ----
`timescale 1ns/10ps
module ddr2_sched_checker (
    input wire logic        CLOCK,
    input wire logic        NRST,
    input wire logic        CE,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        WR_ISSUE,
    input wire logic        RD_ISSUE,
    input wire logic        RD_ALLOW,
    input wire logic        WR_ALLOW,
    input wire logic        ALL_CLOSED,
    input wire logic        REQ_NEW,
    input wire logic        BUS_IDLE,
    input wire logic        CLOSE_ALL_REQ,
    input wire logic        REF_REQ,
    input wire logic        REF_SPECULATIVE,
    input wire logic        TRAFFIC_BLOCK
);
    logic [31:0] turn_r;
    logic [4:0]  wk_r, wg_r, rk_r, rg_r;
    logic        ws_r, rs_r;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    // turnaround word mirror for gap checks
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            turn_r <= 32'h0;
        end else if (CE && PSEL && PENABLE && PREADY && PWRITE
                     && PADDR == ddr2_sched_pkg::TURNAROUND_OFS) begin
            turn_r <= PWDATA;
        end
    end

    // cycles since last write, saturating
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            {ws_r, wk_r, wg_r} <= 11'h0;
        end else if (CE && WR_ISSUE) begin
            {ws_r, wk_r, wg_r} <= {1'b1, 5'h1, turn_r[12:8]};
        end else if (CE && wk_r != 5'h1F) begin
            wk_r <= wk_r + 5'h1;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            {rs_r, rk_r, rg_r} <= 11'h0;
        end else if (CE && RD_ISSUE) begin
            {rs_r, rk_r, rg_r} <= {1'b1, 5'h1, turn_r[4:0]};
        end else if (CE && rk_r != 5'h1F) begin
            rk_r <= rk_r + 5'h1;
        end
    end

    sequence setup_s;
        CE && PSEL && !PENABLE && !PREADY;
    endsequence
    sequence closed_s;
        CLOSE_ALL_REQ && ALL_CLOSED && !REQ_NEW;
    endsequence

    apb_answer_a: assert property (setup_s |=> PREADY)
        else $error("no answer after setup");
    ready_pulse_a: assert property (PREADY && CE |=> !PREADY)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    rd_gap_a: assert property (ws_r |-> RD_ALLOW == (wk_r >= wg_r))
        else $error("read allow off the write-to-read gap");
    wr_gap_a: assert property (rs_r |-> WR_ALLOW == (rk_r >= rg_r))
        else $error("write allow off the read-to-write gap");
    block_group_a: assert property (TRAFFIC_BLOCK |-> CLOSE_ALL_REQ || REF_REQ)
        else $error("traffic blocked outside a group");
    close_ref_a: assert property (closed_s |=> REF_REQ && !CLOSE_ALL_REQ)
        else $error("refresh not started after pages closed");
    ref_exclusive_a: assert property (!(CLOSE_ALL_REQ && REF_REQ))
        else $error("closing pages during refreshes");
    spec_cause_a: assert property ($rose(CLOSE_ALL_REQ) && REF_SPECULATIVE
        |-> $past(BUS_IDLE) && !$past(REQ_NEW))
        else $error("speculative group on a busy bus");
    spec_abort_a: assert property (CLOSE_ALL_REQ && REF_SPECULATIVE && REQ_NEW
        && !ALL_CLOSED |=> !CLOSE_ALL_REQ || TRAFFIC_BLOCK)
        else $error("speculative group not dropped on request");
endmodule : ddr2_sched_checker

bind ddr2_turnaround_refresh_sched ddr2_sched_checker ddr2_sched_checker_inst (
    .CLOCK, .NRST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR,
    .WR_ISSUE, .RD_ISSUE, .RD_ALLOW, .WR_ALLOW, .ALL_CLOSED, .REQ_NEW, .BUS_IDLE,
    .CLOSE_ALL_REQ, .REF_REQ, .REF_SPECULATIVE, .TRAFFIC_BLOCK);

// ---- testbench/ddr2_turnaround_refresh_sched_tb_top.sv ----
`timescale 1ns/10ps
module ddr2_turnaround_refresh_sched_tb_top;
    logic        CLOCK, NRST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er, cl_q, slow;
    logic        WR_ISSUE, RD_ISSUE, ACT_ISSUE, PRE_ISSUE, ALL_CLOSED, REF_DONE, REQ_NEW;
    logic        BUS_IDLE, RD_ALLOW, WR_ALLOW, CLOSE_ALL_REQ, REF_REQ, REF_SPECULATIVE;
    logic        TRAFFIC_BLOCK;
    logic [7:0]  PADDR, PRE_ALLOW, PAGE_CLOSE_REQ, cfg;
    logic [31:0] PWDATA, PRDATA, rd, v;
    logic [2:0]  CMD_BANK, b, bu;
    logic [4:0]  g1, g2, g3, g4;
    logic [7:0]  ofs [2];
    logic [31:0] msk [2];
    int          errors, n_checks, dones, closes, n;

    ddr2_turnaround_refresh_sched ddr2_turnaround_refresh_sched_inst (
        .CLOCK, .NRST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .WR_ISSUE, .RD_ISSUE, .ACT_ISSUE, .PRE_ISSUE, .CMD_BANK, .ALL_CLOSED,
        .REF_DONE, .REQ_NEW, .BUS_IDLE, .PRE_ALLOW, .RD_ALLOW, .WR_ALLOW, .PAGE_CLOSE_REQ,
        .CLOSE_ALL_REQ, .REF_REQ, .REF_SPECULATIVE, .TRAFFIC_BLOCK);
    ddr2_mem_model ddr2_mem_model_inst (.clk(CLOCK), .rst_n(NRST), .slow,
        .close_all_req(CLOSE_ALL_REQ), .ref_req(REF_REQ), .all_closed(ALL_CLOSED),
        .ref_done(REF_DONE));

    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    function automatic logic [7:0] pre_exp(input logic [2:0] bank, input logic ok);
        pre_exp = 8'hFF;
        pre_exp[bank] = ok;
    endfunction : pre_exp

    function automatic logic in_win(input int got, input int want);
        return got >= want - 2 && got <= want + 4;
    endfunction : in_win

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        @(posedge CLOCK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, wr, a, d};
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        w = 0;
        do begin
            @(posedge CLOCK);
            w++;
        end while (PREADY !== 1'b1 && w < 50);
        chk("apb ready", 32'h1, 32'(PREADY));
        rd = PRDATA;
        er = PSLVERR;
        {PSEL, PENABLE} <= 2'b00;
    endtask : apb

    task gap_run(input logic wr, input logic [4:0] g, input logic [4:0] gp);
        @(posedge CLOCK);
        {CMD_BANK, WR_ISSUE, RD_ISSUE} <= {b, wr, !wr};
        for (int k = 1; k < 34; k++) begin
            @(posedge CLOCK);
            {WR_ISSUE, RD_ISSUE} <= 2'b00;
            #1;
            chk("rd/wr allow", 32'(k >= g), 32'(wr ? RD_ALLOW : WR_ALLOW));
            chk("pre allow", 32'(pre_exp(b, k >= gp)), 32'(PRE_ALLOW));
        end
    endtask : gap_run

    task wait_close;
        n = 0;
        do begin
            @(posedge CLOCK);
            #1;
            n++;
        end while (CLOSE_ALL_REQ !== 1'b1 && n < 400);
    endtask : wait_close

    task wait_idle;
        n = 0;
        do begin
            @(posedge CLOCK);
            #1;
            n++;
        end while ((CLOSE_ALL_REQ || REF_REQ) !== 1'b0 && n < 200);
        chk("group end", 32'h1, 32'(n < 200));
    endtask : wait_idle

    task results;
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    always @(posedge CLOCK) begin
        if (REF_DONE === 1'b1) dones++;
        if (CLOSE_ALL_REQ === 1'b1 && cl_q !== 1'b1) closes++;
        cl_q <= CLOSE_ALL_REQ;
    end

    initial begin
        repeat (20000) @(posedge CLOCK);
        errors++;
        results;
    end

    initial begin
        void'($urandom(64856));
        {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA, WR_ISSUE, RD_ISSUE} = '0;
        {ACT_ISSUE, PRE_ISSUE, CMD_BANK, REQ_NEW, BUS_IDLE, slow, b} = '0;
        {errors, n_checks, dones, closes} = '0;
        CE = 1'b1;
        cfg = ddr2_sched_pkg::SCHED_CFG_OFS;
        ofs = '{ddr2_sched_pkg::TURNAROUND_OFS, ddr2_sched_pkg::REFRESH_CTL_OFS};
        msk = '{ddr2_sched_pkg::TURNAROUND_MASK, ddr2_sched_pkg::REFRESH_CTL_MASK};
        repeat (5) @(posedge CLOCK);
        NRST <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk("reset value", ddr2_sched_pkg::REG_RESET, rd);
            for (int j = 0; j < 4; j++) begin
                v = j ? $urandom : 32'hFFFFFFFF;
                apb(1'b1, ofs[i], v);
                apb(1'b0, ofs[i], 32'h0);
                chk("readback", v & msk[i], rd);
            end
        end
        apb(1'b1, 8'h28, 32'hFFFFFFFF);
        chk("unmapped error", 32'h1, 32'(er));
        for (int i = 0; i < 12; i++) begin
            {g1, g2, g3, g4} = 20'($urandom);
            if (i < 3) {g1, g2, g3, g4} = {4{i == 2 ? 5'h1F : 5'(i)}};
            if (i == 3) g2 = 5'(5 + 8 / 2 + 2 - 4);
            b = 3'($urandom);
            apb(1'b1, ofs[0], {3'h0, g3, 3'h0, g4, 3'h0, g1, 3'h0, g2});
            gap_run(1'b1, g1, g3);
            gap_run(1'b0, g2, g4);
        end
        for (int i = 0; i < 3; i++) begin
            bu = i == 0 ? 3'h0 : i == 1 ? 3'h7 : 3'($urandom_range(1, 6));
            apb(1'b1, ofs[1], {19'h0, 5'h1F, 3'h0, i == 2, 1'b0, bu});
            apb(1'b1, cfg, 32'h00010000);
            {dones, closes} = '0;
            wait_close;
            chk("critical start", 32'h1, 32'(in_win(n, (bu + 1 - (i == 2)) * 32)));
            chk("traffic block", 32'h1, 32'(TRAFFIC_BLOCK));
            apb(1'b1, cfg, 32'h0);
            wait_idle;
            chk("group refreshes", 32'(bu + 1 - (i == 2)), 32'(dones));
            chk("page closings", 32'h1, 32'(closes));
            apb(1'b0, ddr2_sched_pkg::SCHED_STAT_OFS, 32'h0);
            chk("pending left", 32'h0, {28'h0, rd[3:0]});
        end
        apb(1'b1, ofs[1], {19'h0, 5'h01, 4'h0, 1'b0, 3'h3});
        apb(1'b1, cfg, 32'h00010000);
        {dones, closes} = '0;
        repeat (40) @(posedge CLOCK);
        apb(1'b1, cfg, 32'h0);
        chk("busy bus group", 32'h0, 32'(closes));
        {BUS_IDLE, slow} <= 2'b11;
        wait_close;
        chk("idle wait", 32'h1, 32'(in_win(n, 32)));
        chk("speculative", 32'h1, 32'(REF_SPECULATIVE));
        chk("early block", 32'h0, 32'(TRAFFIC_BLOCK));
        @(posedge CLOCK);
        {REQ_NEW, BUS_IDLE} <= 2'b10;
        @(posedge CLOCK);
        {REQ_NEW, slow} <= 2'b00;
        @(posedge CLOCK);
        #1;
        chk("abort on request", 32'h0, 32'(CLOSE_ALL_REQ));
        @(posedge CLOCK);
        BUS_IDLE <= 1'b1;
        wait_close;
        wait_idle;
        chk("speculative refreshes", 32'h1, 32'(dones));
        @(posedge CLOCK);
        {CMD_BANK, ACT_ISSUE} <= {b, 1'b1};
        @(posedge CLOCK);
        {ACT_ISSUE, RD_ISSUE} <= 2'b01;
        @(posedge CLOCK);
        RD_ISSUE <= 1'b0;
        repeat (2) @(posedge CLOCK);
        #1;
        chk("page close", 32'(8'h1 << b), 32'(PAGE_CLOSE_REQ));
        @(posedge CLOCK);
        PRE_ISSUE <= 1'b1;
        @(posedge CLOCK);
        PRE_ISSUE <= 1'b0;
        @(posedge CLOCK);
        #1;
        chk("page close cleared", 32'h0, 32'(PAGE_CLOSE_REQ));
        results;
    end
endmodule : ddr2_turnaround_refresh_sched_tb_top
